// [logic/icache_ctrl.sv]
`timescale 1ns/1ps
module icache_ctrl
    import icache_pkg::*;
(
    input  wire logic        CLK_SYS_IN,     // System clock, 20 MHz
    input  wire logic        RST_IN,         // Asynchronous reset, active high
    input  wire logic        ICACHE_EN_IN,   // instr_cache_enable_bit
    input  wire logic        DCACHE_EN_IN,   // data_cache_enable_bit
    input  wire logic        FETCH_REQ_IN,   // Fetch request
    input  wire logic [31:0] FETCH_ADDR_IN,  // Fetch byte address
    output logic             FETCH_READY_OUT,// Fetch request may be taken
    output logic             FETCH_VALID_OUT,// Instruction word valid, pulse
    output logic [31:0]      FETCH_DATA_OUT, // Instruction word
    output logic             BUS_REQ_OUT,    // Bus read request, held to grant
    output logic [31:0]      BUS_ADDR_OUT,   // Bus read address
    output logic             BUS_BURST_OUT,  // High for a four-word burst
    input  wire logic        BUS_GNT_IN,     // Bus accepts the request
    input  wire logic        BUS_RVALID_IN,  // Read data beat valid
    input  wire logic [31:0] BUS_RDATA_IN,   // Read data beat
    input  wire logic        LOAD_LOCK_IN,   // Lock the line filled by this miss
    input  wire logic        FLUSH_LINE_IN,  // Flush the line at MAINT_ADDR_IN unless it is locked
    input  wire logic        FLUSH_ALL_IN,   // Flush every line
    input  wire logic        UNLOCK_ALL_IN,  // Unlock every line
    input  wire logic [31:0] MAINT_ADDR_IN,  // Address for line flush
    output logic             RAM_AVAIL_OUT,  // On-chip RAM present
    output logic [31:0]      RAM_BASE_OUT,   // On-chip RAM start address
    output logic [31:0]      RAM_SIZE_OUT,   // On-chip RAM size in bytes
    output logic [3:0]       WBUF_WORDS_OUT  // Write buffer capacity in words
);
    function automatic logic [1:0] wrap_word(input logic [1:0] first, input logic [1:0] beat);
        wrap_word = 2'(first + beat);
    endfunction

    logic [31:0]      data_mem [WAYS][SETS][WORDS_PER_LINE];
    logic [TAG_W-1:0] tag_mem  [WAYS][SETS];
    logic [WAYS-1:0][SETS-1:0] valid_bits;
    logic [WAYS-1:0][SETS-1:0] lock_bits;
    logic [SETS-1:0]  lru_bits;

    ctrl_state_t      state;
    bus_req_t         bus_req;
    ocram_map_t       ram_map;
    logic             icache_on;
    logic             ready;
    logic             fetch_valid;
    logic [31:0]      fetch_data;
    logic [1:0]       beat;
    logic [1:0]       crit_word;
    logic [IDX_W-1:0] fill_idx;
    logic [TAG_W-1:0] fill_tag;
    logic             fill_way;
    logic             fill_lock;

    fetch_addr_t      fa;
    fetch_addr_t      ma;
    logic             cacheable;
    logic [1:0]       hit_vec;
    logic             hit;
    logic             hit_way;
    logic [31:0]      hit_word;
    logic             maint_any;
    logic             take;
    logic             victim_way;
    logic             victim_found;
    logic             fill_beat;
    logic             fill_done;

    assign fa        = fetch_addr_t'(FETCH_ADDR_IN);
    assign ma        = fetch_addr_t'(MAINT_ADDR_IN);
    assign cacheable = icache_on && !fa.nc;
    assign hit_vec[0] = valid_bits[0][fa.index] && (tag_mem[0][fa.index] == fa.tag);
    assign hit_vec[1] = valid_bits[1][fa.index] && (tag_mem[1][fa.index] == fa.tag);
    assign hit       = cacheable && (hit_vec != 2'b00);
    assign hit_way   = hit_vec[1];
    assign hit_word  = data_mem[hit_way][fa.index][fa.word];
    assign maint_any = FLUSH_LINE_IN || FLUSH_ALL_IN || UNLOCK_ALL_IN;
    // Maintenance takes the cycle, so a fetch offered together with it waits.
    assign take      = FETCH_REQ_IN && ready && (state == ST_IDLE) && !maint_any;
    assign fill_beat = (state == ST_FILL) && BUS_RVALID_IN;
    assign fill_done = fill_beat && (beat == LAST_BEAT);

    victim_select u_victim (
        .valid_in  ({valid_bits[1][fa.index], valid_bits[0][fa.index]}),
        .lock_in   ({lock_bits[1][fa.index], lock_bits[0][fa.index]}),
        .lru_in    (lru_bits[fa.index]),
        .way_out   (victim_way),
        .found_out (victim_found)
    );

    // Enable bits are sampled so that the cache always starts disabled.
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            icache_on <= RESET_CACHE_ON;
        end else begin
            icache_on <= ICACHE_EN_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ram_map        <= '0;
            WBUF_WORDS_OUT <= 4'h0;
        end else begin
            WBUF_WORDS_OUT <= WBUF_WORDS_CODE;
            unique case ({ICACHE_EN_IN, DCACHE_EN_IN})
                2'b00: ram_map <= '{avail: 1'b1, base: OCRAM_LOW_BASE, size: OCRAM_SIZE_BOTH};
                2'b01: ram_map <= '{avail: 1'b1, base: OCRAM_LOW_BASE, size: OCRAM_SIZE_I};
                2'b10: ram_map <= '{avail: 1'b1, base: OCRAM_HIGH_BASE, size: OCRAM_SIZE_D};
                2'b11: ram_map <= '{avail: 1'b0, base: OCRAM_LOW_BASE, size: OCRAM_SIZE_NONE};
            endcase
        end
    end

    assign RAM_AVAIL_OUT = ram_map.avail;
    assign RAM_BASE_OUT  = ram_map.base;
    assign RAM_SIZE_OUT  = ram_map.size;

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state     <= ST_IDLE;
            ready     <= 1'b1;
            beat      <= 2'h0;
            crit_word <= 2'h0;
            fill_idx  <= '0;
            fill_tag  <= '0;
            fill_way  <= 1'b0;
            fill_lock <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    beat <= 2'h0;
                    if (take && !hit) begin
                        ready     <= 1'b0;
                        crit_word <= fa.word;
                        fill_idx  <= fa.index;
                        fill_tag  <= fa.tag;
                        fill_way  <= victim_way;
                        fill_lock <= LOAD_LOCK_IN;
                        // With both ways locked the miss is served uncached.
                        if (cacheable && victim_found) begin
                            state <= ST_FILL;
                        end else begin
                            state <= ST_SINGLE;
                        end
                    end
                end
                ST_FILL: begin
                    if (fill_beat) begin
                        beat <= 2'(beat + 2'h1);
                    end
                    if (fill_done) begin
                        state <= ST_IDLE;
                        ready <= 1'b1;
                    end
                end
                ST_SINGLE: begin
                    if (BUS_RVALID_IN) begin
                        state <= ST_IDLE;
                        ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bus_req <= '0;
        end else if (take && !hit) begin
            bus_req.req   <= 1'b1;
            bus_req.addr  <= {FETCH_ADDR_IN[31:2], WORD_ALIGN};
            bus_req.burst <= cacheable && victim_found;
        end else if (bus_req.req && BUS_GNT_IN) begin
            bus_req.req <= 1'b0;
        end
    end

    assign BUS_REQ_OUT   = bus_req.req;
    assign BUS_ADDR_OUT  = bus_req.addr;
    assign BUS_BURST_OUT = bus_req.burst;

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            fetch_valid <= 1'b0;
            fetch_data  <= 32'h0000_0000;
        end else begin
            fetch_valid <= 1'b0;
            if (take && hit) begin
                fetch_valid <= 1'b1;
                fetch_data  <= hit_word;
            end else if ((fill_beat && beat == 2'h0) || (state == ST_SINGLE && BUS_RVALID_IN)) begin
                fetch_valid <= 1'b1;
                fetch_data  <= BUS_RDATA_IN;
            end
        end
    end

    assign FETCH_READY_OUT = ready;
    assign FETCH_VALID_OUT = fetch_valid;
    assign FETCH_DATA_OUT  = fetch_data;

    // Arrays are left unreset; the valid bits alone guard their contents.
    always_ff @(posedge CLK_SYS_IN) begin
        if (fill_beat) begin
            data_mem[fill_way][fill_idx][wrap_word(crit_word, beat)] <= BUS_RDATA_IN;
        end
        if (fill_done) begin
            tag_mem[fill_way][fill_idx] <= fill_tag;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            valid_bits <= '0;
        end else if (fill_done) begin
            valid_bits[fill_way][fill_idx] <= 1'b1;
        end else if (state == ST_IDLE && FLUSH_ALL_IN) begin
            valid_bits <= '0;
        end else if (state == ST_IDLE && FLUSH_LINE_IN) begin
            for (int w = 0; w < WAYS; w++) begin
                if (tag_mem[w][ma.index] == ma.tag && !lock_bits[w][ma.index]) begin
                    valid_bits[w][ma.index] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lock_bits <= '0;
        end else if (fill_done && fill_lock) begin
            lock_bits[fill_way][fill_idx] <= 1'b1;
        end else if (state == ST_IDLE && (FLUSH_ALL_IN || UNLOCK_ALL_IN)) begin
            lock_bits <= '0;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lru_bits <= '0;
        end else if (take && hit) begin
            lru_bits[fa.index] <= !hit_way;
        end else if (fill_done) begin
            lru_bits[fill_idx] <= !fill_way;
        end
    end

    sequence s_miss_taken;
        take && !hit && cacheable && victim_found;
    endsequence

    sequence s_burst_issued;
        BUS_REQ_OUT && BUS_BURST_OUT && (state == ST_FILL);
    endsequence

    property p_reset_disabled;
        @(posedge CLK_SYS_IN) disable iff (RST_IN) $past(RST_IN) |-> !icache_on && (valid_bits == '0);
    endproperty
    a_reset_disabled: assert property (p_reset_disabled) else $error("cache not cleared after reset");

    property p_hit_word;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            take && hit |=> FETCH_VALID_OUT && (FETCH_DATA_OUT == $past(hit_word)) && FETCH_READY_OUT;
    endproperty
    a_hit_word: assert property (p_hit_word) else $error("hit word not returned next cycle");

    property p_miss_burst;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            s_miss_taken |=> s_burst_issued ##0 (BUS_ADDR_OUT == {$past(FETCH_ADDR_IN[31:2]), WORD_ALIGN});
    endproperty
    a_miss_burst: assert property (p_miss_burst) else $error("miss did not issue burst");

    property p_victim_ok;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            s_miss_taken |-> !lock_bits[victim_way][fa.index]
                && (!valid_bits[victim_way][fa.index] || valid_bits[!victim_way][fa.index]
                    || lock_bits[!victim_way][fa.index]);
    endproperty
    a_victim_ok: assert property (p_victim_ok) else $error("bad victim choice");

    // Only a set with both ways valid and unlocked leaves the choice to the LRU bit.
    property p_lru_pick;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            s_miss_taken ##0 (valid_bits[0][fa.index] && valid_bits[1][fa.index]
                && !lock_bits[0][fa.index] && !lock_bits[1][fa.index]) |-> victim_way == lru_bits[fa.index];
    endproperty
    a_lru_pick: assert property (p_lru_pick) else $error("victim ignores LRU bit");

    property p_first_beat;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            fill_beat && (beat == 2'h0) |=> FETCH_VALID_OUT && (FETCH_DATA_OUT == $past(BUS_RDATA_IN));
    endproperty
    a_first_beat: assert property (p_first_beat) else $error("critical word not forwarded");

    property p_wrap_order;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            fill_beat |=> data_mem[fill_way][fill_idx][$past(wrap_word(crit_word, beat))] == $past(BUS_RDATA_IN);
    endproperty
    a_wrap_order: assert property (p_wrap_order) else $error("fill word stored at wrong slot");

    property p_fill_end;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            fill_done |=> (state == ST_IDLE) && valid_bits[fill_way][fill_idx]
                && (lru_bits[fill_idx] == !fill_way) && FETCH_READY_OUT;
    endproperty
    a_fill_end: assert property (p_fill_end) else $error("fill did not complete line");

    property p_uncached;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            take && fa.nc |=> BUS_REQ_OUT && !BUS_BURST_OUT && (state == ST_SINGLE) && $stable(lru_bits);
    endproperty
    a_uncached: assert property (p_uncached) else $error("non-cacheable fetch not bypassed");

    property p_lock_flush;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            (state == ST_IDLE) && FLUSH_LINE_IN && !FLUSH_ALL_IN && lock_bits[0][ma.index]
                && valid_bits[0][ma.index] |=> valid_bits[0][$past(ma.index)];
    endproperty
    a_lock_flush: assert property (p_lock_flush) else $error("locked line flushed");

    property p_ram_map;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
            !ICACHE_EN_IN && DCACHE_EN_IN |=> RAM_AVAIL_OUT && (RAM_BASE_OUT == OCRAM_LOW_BASE)
                && (RAM_SIZE_OUT == OCRAM_SIZE_I);
    endproperty
    a_ram_map: assert property (p_ram_map) else $error("on-chip RAM map wrong");
endmodule

// [logic/icache_pkg.sv]
package icache_pkg;
    localparam int IDX_W          = 8;
    localparam int TAG_W          = 19;
    localparam int WAYS           = 2;
    localparam int WORDS_PER_LINE = 4;
    localparam int SETS           = 256;
    localparam int ICACHE_BYTES   = SETS * WAYS * WORDS_PER_LINE * 4;
    localparam int DCACHE_SETS    = 64;
    localparam int DCACHE_BYTES   = DCACHE_SETS * WAYS * WORDS_PER_LINE * 4;
    localparam int WBUF_WORDS     = 8;

    localparam logic [1:0]  LAST_BEAT       = 2'h3;
    localparam logic [1:0]  WORD_ALIGN      = 2'h0;
    localparam logic [3:0]  WBUF_WORDS_CODE = 4'h8;
    localparam logic [31:0] OCRAM_LOW_BASE  = 32'hFFE0_0000;
    localparam logic [31:0] OCRAM_HIGH_BASE = 32'hFFE0_2000;
    localparam logic [31:0] OCRAM_SIZE_BOTH = 32'h0000_2800;
    localparam logic [31:0] OCRAM_SIZE_I    = 32'h0000_2000;
    localparam logic [31:0] OCRAM_SIZE_D    = 32'h0000_0800;
    localparam logic [31:0] OCRAM_SIZE_NONE = 32'h0000_0000;
    localparam logic        RESET_CACHE_ON  = 1'b0;

    // Bit 31 is the non-cacheable flag, then tag, set index, word and byte.
    typedef struct packed {
        logic              nc;
        logic [TAG_W-1:0]  tag;
        logic [IDX_W-1:0]  index;
        logic [1:0]        word;
        logic [1:0]        byte_sel;
    } fetch_addr_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic        burst;
    } bus_req_t;

    typedef struct packed {
        logic        avail;
        logic [31:0] base;
        logic [31:0] size;
    } ocram_map_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_FILL   = 3'b010,
        ST_SINGLE = 3'b100
    } ctrl_state_t;
endpackage

// [logic/victim_select.sv]
`timescale 1ns/1ps
module victim_select
    import icache_pkg::*;
(
    input  wire logic [1:0] valid_in,   // Valid bits of both ways
    input  wire logic [1:0] lock_in,    // Lock bits of both ways
    input  wire logic       lru_in,     // Way not most recently used
    output logic            way_out,    // Chosen way
    output logic            found_out   // High when a way may be replaced
);
    always_comb begin
        way_out   = 1'b0;
        found_out = 1'b1;
        if (!valid_in[0] && !lock_in[0]) begin
            way_out = 1'b0;
        end else if (!valid_in[1] && !lock_in[1]) begin
            way_out = 1'b1;
        end else if (lock_in == 2'b00) begin
            way_out = lru_in;
        end else if (!lock_in[0]) begin
            way_out = 1'b0;
        end else if (!lock_in[1]) begin
            way_out = 1'b1;
        end else begin
            found_out = 1'b0;
        end
    end
endmodule

// [dv/bus_mem_model.sv]
`timescale 1ns/1ps
module bus_mem_model (
    input  wire logic        clk_in,         // System clock
    input  wire logic        rst_in,         // Reset, active high
    input  wire logic        req_in,         // Read request
    input  wire logic [31:0] addr_in,        // Read address
    input  wire logic        burst_in,       // Four-beat wrapping burst
    input  wire logic        slow_in,        // Stretch grant and beats
    output logic             gnt_out,        // Request accepted
    output logic             rvalid_out,     // Read beat valid
    output logic [31:0]      rdata_out,      // Read beat data
    output logic [31:0]      last_addr_out,  // Latest request address
    output logic             last_burst_out, // Latest request burst flag
    output logic [7:0]       n_req_out       // Requests seen
);
    logic [31:0] a;
    logic        b;
    logic [1:0]  w;

    function automatic logic [31:0] mem_word(input logic [31:0] wa);
        return {wa[31:16] ^ ~wa[15:0], wa[15:0]};
    endfunction

    initial begin
        gnt_out = 1'b0;
        rvalid_out = 1'b0;
        rdata_out = 32'h0000_0000;
        last_addr_out = 32'h0000_0000;
        last_burst_out = 1'b0;
        n_req_out = 8'h00;
    end

    // Idle data lines toggle so that a stale beat can never be mistaken for a fresh one.
    always begin
        @(posedge clk_in);
        rdata_out <= ~rdata_out;
        if (!rst_in && req_in) begin
            a = addr_in;
            b = burst_in;
            last_addr_out <= addr_in;
            last_burst_out <= burst_in;
            n_req_out <= n_req_out + 8'h01;
            if (slow_in) repeat (2) @(posedge clk_in);
            gnt_out <= 1'b1;
            @(posedge clk_in);
            gnt_out <= 1'b0;
            for (int k = 0; k <= (b ? 3 : 0); k++) begin
                if (slow_in) begin
                    rvalid_out <= 1'b0;
                    rdata_out <= ~rdata_out;
                    @(posedge clk_in);
                end
                w = a[3:2] + 2'(k);
                rvalid_out <= 1'b1;
                rdata_out <= mem_word({a[31:4], w, 2'b00});
                @(posedge clk_in);
            end
            rvalid_out <= 1'b0;
        end
    end
endmodule

// [dv/instruction_cache_controller_tb.sv]
`timescale 1ns/1ps
module instruction_cache_controller_tb;
    typedef struct packed {
        logic [31:0] addr;
        logic        lock;
        logic        miss;
        logic        burst;
    } row_t;

    localparam row_t ROWS [16] = '{
        '{32'h0000_1008, 1'b0, 1'b1, 1'b1},
        '{32'h0000_1004, 1'b0, 1'b0, 1'b0},
        '{32'h0000_100C, 1'b0, 1'b0, 1'b0},
        '{32'h0000_2008, 1'b0, 1'b1, 1'b1},
        '{32'h0000_1000, 1'b0, 1'b0, 1'b0},
        '{32'h0000_3000, 1'b0, 1'b1, 1'b1},
        '{32'h0000_1004, 1'b0, 1'b0, 1'b0},
        '{32'h0000_2000, 1'b0, 1'b1, 1'b1},
        '{32'h4000_1000, 1'b0, 1'b1, 1'b1},
        '{32'h0000_1000, 1'b0, 1'b1, 1'b1},
        '{32'h4000_1000, 1'b0, 1'b0, 1'b0},
        '{32'h8000_1000, 1'b0, 1'b1, 1'b0},
        '{32'h8000_1000, 1'b0, 1'b1, 1'b0},
        '{32'h0000_0FF4, 1'b0, 1'b1, 1'b1},
        '{32'h0000_0FF0, 1'b0, 1'b0, 1'b0},
        '{32'h0000_1000, 1'b0, 1'b0, 1'b0}
    };
    localparam logic [31:0] RAM_BASE_EXP [4] = '{32'hFFE0_0000, 32'hFFE0_0000, 32'hFFE0_2000, 32'h0000_0000};
    localparam logic [31:0] RAM_SIZE_EXP [4] = '{32'h0000_2800, 32'h0000_2000, 32'h0000_0800, 32'h0000_0000};

    logic        clk = 1'b0;
    logic        rst, ice, dce, req, lock, slow;
    logic [31:0] addr, maddr;
    logic [2:0]  maint;
    logic        ready, valid, breq, bburst, gnt, rvalid, ram_avail, last_burst;
    logic [31:0] data, baddr, rdata, ram_base, ram_size, last_addr;
    logic [3:0]  wbuf;
    logic [7:0]  n_req;
    int          error_cnt = 0;
    int          n_checks = 0;

    always #25 clk = ~clk;

    icache_ctrl u_dut (
        .CLK_SYS_IN(clk), .RST_IN(rst), .ICACHE_EN_IN(ice), .DCACHE_EN_IN(dce),
        .FETCH_REQ_IN(req), .FETCH_ADDR_IN(addr), .FETCH_READY_OUT(ready),
        .FETCH_VALID_OUT(valid), .FETCH_DATA_OUT(data), .BUS_REQ_OUT(breq),
        .BUS_ADDR_OUT(baddr), .BUS_BURST_OUT(bburst), .BUS_GNT_IN(gnt),
        .BUS_RVALID_IN(rvalid), .BUS_RDATA_IN(rdata), .LOAD_LOCK_IN(lock),
        .FLUSH_LINE_IN(maint[0]), .FLUSH_ALL_IN(maint[1]), .UNLOCK_ALL_IN(maint[2]),
        .MAINT_ADDR_IN(maddr), .RAM_AVAIL_OUT(ram_avail), .RAM_BASE_OUT(ram_base),
        .RAM_SIZE_OUT(ram_size), .WBUF_WORDS_OUT(wbuf)
    );

    bus_mem_model u_mem (
        .clk_in(clk), .rst_in(rst), .req_in(breq), .addr_in(baddr), .burst_in(bburst),
        .slow_in(slow), .gnt_out(gnt), .rvalid_out(rvalid), .rdata_out(rdata),
        .last_addr_out(last_addr), .last_burst_out(last_burst), .n_req_out(n_req)
    );

    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {a[31:16] ^ ~{a[15:2], 2'b00}, a[15:2], 2'b00};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Inputs are launched just after an edge, so the next edge is the first one that can take them.
    task automatic fetch(input logic [31:0] a, input logic lk, input logic exp_miss, input logic exp_burst);
        logic [7:0] n0;
        int         t;
        n0 = n_req;
        req <= 1'b1;
        addr <= a;
        lock <= lk;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ready !== 1'b1 && t < 200);
        check("take_wait", 32'(t >= 200), 32'h0000_0000);
        req <= 1'b0;
        lock <= 1'b0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (valid !== 1'b1 && t < 200);
        check("valid_wait", 32'(t >= 200), 32'h0000_0000);
        check("fetch_data", data, word_at(a));
        check("bus_requests", 32'(n_req - n0), 32'(exp_miss));
        if (exp_miss) begin
            check("bus_addr", last_addr, {a[31:2], 2'b00});
            check("bus_burst", 32'(last_burst), 32'(exp_burst));
        end else begin
            check("hit_latency", 32'(t), 32'h0000_0001);
        end
    endtask

    // Maintenance is ignored during a fill, so wait until the controller is idle again.
    task automatic pulse(input int which, input logic [31:0] a);
        int t;
        t = 0;
        while (ready !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        check("maint_wait", 32'(t >= 200), 32'h0000_0000);
        maint[which] <= 1'b1;
        maddr <= a;
        @(posedge clk);
        maint <= 3'b000;
        @(posedge clk);
    endtask

    task automatic reset_checks();
        check("ready_in_reset", 32'(ready), 32'h0000_0001);
        check("valid_in_reset", 32'(valid), 32'h0000_0000);
        check("busreq_in_reset", 32'(breq), 32'h0000_0000);
        check("wbuf_in_reset", 32'(wbuf), 32'h0000_0000);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        rst <= 1'b1;
        {ice, dce, req, lock, slow} <= 5'h00;
        addr <= 32'h0000_0000;
        maddr <= 32'h0000_0000;
        maint <= 3'b000;
        repeat (8) @(posedge clk);
        reset_checks();
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("wbuf_words", 32'(wbuf), 32'h0000_0008);
        for (int i = 0; i < 4; i++) begin
            {ice, dce} <= 2'(i);
            repeat (2) @(posedge clk);
            check("ram_avail", 32'(ram_avail), 32'(i != 3));
            check("ram_size", ram_size, RAM_SIZE_EXP[i]);
            if (i != 3) check("ram_base", ram_base, RAM_BASE_EXP[i]);
        end
        foreach (ROWS[i]) fetch(ROWS[i].addr, ROWS[i].lock, ROWS[i].miss, ROWS[i].burst);
        slow <= 1'b1;
        pulse(1, 32'h0000_0000);
        fetch(32'h0000_1000, 1'b1, 1'b1, 1'b1);
        fetch(32'h0000_2000, 1'b0, 1'b1, 1'b1);
        fetch(32'h0000_3000, 1'b0, 1'b1, 1'b1);
        fetch(32'h0000_1000, 1'b0, 1'b0, 1'b0);
        pulse(0, 32'h0000_1000);
        fetch(32'h0000_1000, 1'b0, 1'b0, 1'b0);
        pulse(0, 32'h0000_3000);
        fetch(32'h0000_3000, 1'b0, 1'b1, 1'b1);
        pulse(2, 32'h0000_0000);
        pulse(0, 32'h0000_1000);
        fetch(32'h0000_1000, 1'b0, 1'b1, 1'b1);
        pulse(1, 32'h0000_0000);
        fetch(32'h0000_1000, 1'b1, 1'b1, 1'b1);
        fetch(32'h0000_2000, 1'b1, 1'b1, 1'b1);
        fetch(32'h0000_3000, 1'b0, 1'b1, 1'b0);
        ice <= 1'b0;
        @(posedge clk);
        fetch(32'h0000_3000, 1'b0, 1'b1, 1'b0);
        ice <= 1'b1;
        slow <= 1'b0;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        reset_checks();
        rst <= 1'b0;
        fetch(32'h0000_3000, 1'b0, 1'b1, 1'b0);
        fetch(32'h0000_3004, 1'b0, 1'b1, 1'b1);
        finish_test();
    end
endmodule
